// File: design/gfx_cfg.svh
// Address, index, field and miscellaneous constants of the graphics pixel datapath
`ifndef GFX_CFG_SVH
`define GFX_CFG_SVH

// I/O port addresses
`define GFX_INDEX_ADDR   16'h03CE
`define GFX_DATA_ADDR    16'h03CF
`define CRT_INDEX_MONO   16'h03B4
`define CRT_DATA_MONO    16'h03B5
`define CRT_INDEX_COLOUR 16'h03D4
`define CRT_DATA_COLOUR  16'h03D5

// Graphics controller indices
`define IDX_FILL         4'h0
`define IDX_FILL_EN      4'h1
`define IDX_REF          4'h2
`define IDX_OPSHIFT      4'h3
`define IDX_RD_PLANE     4'h4
`define IDX_MODE         4'h5
`define IDX_MAP          4'h6
`define IDX_IGNORE       4'h7
`define IDX_BIT_MASK     4'h8

// Display timing index of the latch read-back register
`define CRT_IDX_LATCH    8'h22

// Mode register fields
`define MODE_WMODE_HI    1
`define MODE_WMODE_LO    0
`define MODE_COMPARE_READ_BIT 3
`define MODE_STORE_MASK  8'h7B

// Logic op / shift fields
`define OP_HI            4
`define OP_LO            3
`define SHIFT_HI         2
`define SHIFT_LO         0

// Miscellaneous
`define READ_ZERO        8'h00
`define ALL_ONES         8'hFF

`endif

// File: design/gfx_pkg.sv
// Types shared by the graphics pixel datapath
package gfx_pkg;

    typedef logic [3:0][7:0] planes_t;

    typedef enum logic [1:0] {
        WMODE_0 = 2'h0,
        WMODE_1 = 2'h1,
        WMODE_2 = 2'h2,
        WMODE_3 = 2'h3
    } write_mode_t;

    typedef enum logic [1:0] {
        OP_PASS = 2'h0,
        OP_AND  = 2'h1,
        OP_OR   = 2'h2,
        OP_XOR  = 2'h3
    } logic_op_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  data;
    } io_req_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] data;
    } mem_req_t;

    typedef struct packed {
        logic [3:0] gidx;
        logic [7:0] cidx;
        logic [3:0] fill;
        logic [3:0] fill_en;
        logic [3:0] ref_col;
        logic [4:0] op_shift;
        logic [1:0] rd_plane;
        logic [7:0] mode;
        logic [3:0] map;
        logic [3:0] ignore;
        logic [7:0] bit_mask;
        planes_t    latch;
        logic [7:0] io_rdata;
        logic       io_rvalid;
        planes_t    plane_wdata;
        logic       plane_we;
        logic [7:0] mem_rdata;
        logic       mem_rvalid;
    } gfx_state_t;

endpackage

// File: design/planar_graphics_pixel_datapath.sv
// Graphics controller register set and per-pixel datapath for four memory planes
// Functional notes
// - The index port keeps a 4-bit selector and reads zero in its upper four bits.
// - A data port read or write reaches the register that the current index selects.
// - In write modes 0 and 3 each fill colour bit is spread over all eight bits of its plane.
// - In write mode 0 an enabled plane takes the fill colour, a disabled one the host data.
// - In write mode 3 the plane enables are ignored and the fill colour feeds every plane.
// - In read mode 1 each bit position reads one where the planes match the reference colour.
// - In write modes 0 and 3 host write data is rotated right by the 3-bit shift count; zero leaves it as is.
// - The 2-bit logic op passes, ANDs, ORs or XORs the write data with the latches.
// - The logic op acts in write modes 0, 2 and 3 and not in write mode 1.
// - A read-only register returns the latch byte picked by the read plane choice.
// - Unused upper bits of fill, enable, reference and op/shift registers read zero.
// - A 2-bit field of the mode register selects one of four host write modes.
// - A mode bit selects compare reads when set and single plane reads when clear.
// - In compare reads a plane whose ignore-mask bit is zero is left out of the test.
// - A zero bit-mask bit writes that bit of every plane from the latches.
`timescale 1ns/1ps
`include "gfx_cfg.svh"

module planar_graphics_pixel_datapath (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire gfx_pkg::io_req_t io_req,
    output logic [7:0]            io_rdata,
    output logic                  io_rvalid,
    input  wire gfx_pkg::mem_req_t mem_req,
    input  wire gfx_pkg::planes_t plane_rdata,
    output gfx_pkg::planes_t      plane_wdata,
    output logic                  plane_we,
    output logic [7:0]            mem_rdata,
    output logic                  mem_rvalid
);

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic [7:0] rotate_right(input logic [7:0] d, input logic [2:0] n);
        logic [15:0] t;
        t = {d, d} >> n;
        return t[7:0];
    endfunction

    function automatic logic [7:0] apply_op(input logic [1:0] op,
                                            input logic [7:0] d,
                                            input logic [7:0] l);
        logic [7:0] r;
        case (gfx_pkg::logic_op_t'(op))
            gfx_pkg::OP_PASS: r = d;
            gfx_pkg::OP_AND:  r = d & l;
            gfx_pkg::OP_OR:   r = d | l;
            gfx_pkg::OP_XOR:  r = d ^ l;
            default:          r = d;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] spread(input logic b);
        return {8{b}};
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    gfx_pkg::gfx_state_t st;
    gfx_pkg::gfx_state_t next_st;

    logic [1:0] wmode;
    logic [1:0] op;
    logic [2:0] shift;
    logic [7:0] rotated;
    logic       crt_idx_hit;
    logic       crt_data_hit;

    assign wmode = st.mode[`MODE_WMODE_HI:`MODE_WMODE_LO];
    assign op    = st.op_shift[`OP_HI:`OP_LO];
    assign shift = st.op_shift[`SHIFT_HI:`SHIFT_LO];
    assign rotated = rotate_right(mem_req.data, shift);
    assign crt_idx_hit  = (io_req.addr == `CRT_INDEX_MONO) ||
                          (io_req.addr == `CRT_INDEX_COLOUR);
    assign crt_data_hit = (io_req.addr == `CRT_DATA_MONO) ||
                          (io_req.addr == `CRT_DATA_COLOUR);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [7:0] src;
        logic [7:0] mask;
        logic [7:0] rd;
        src  = `READ_ZERO;
        mask = `READ_ZERO;
        rd   = `READ_ZERO;
        next_st = st;
        next_st.io_rvalid  = 1'b0;
        next_st.plane_we   = 1'b0;
        next_st.mem_rvalid = 1'b0;

        // Register writes through the index/data pair
        if (io_req.wr) begin
            if (io_req.addr == `GFX_INDEX_ADDR) begin
                next_st.gidx = io_req.data[3:0];
            end else if (io_req.addr == `GFX_DATA_ADDR) begin
                case (st.gidx)
                    `IDX_FILL:     next_st.fill     = io_req.data[3:0];
                    `IDX_FILL_EN:  next_st.fill_en  = io_req.data[3:0];
                    `IDX_REF:      next_st.ref_col  = io_req.data[3:0];
                    `IDX_OPSHIFT:  next_st.op_shift = io_req.data[4:0];
                    `IDX_RD_PLANE: next_st.rd_plane = io_req.data[1:0];
                    `IDX_MODE:     next_st.mode     = io_req.data & `MODE_STORE_MASK;
                    `IDX_MAP:      next_st.map      = io_req.data[3:0];
                    `IDX_IGNORE:   next_st.ignore   = io_req.data[3:0];
                    `IDX_BIT_MASK: next_st.bit_mask = io_req.data;
                    default: ;
                endcase
            end else if (crt_idx_hit) begin
                next_st.cidx = io_req.data;
            end
        end

        // Register reads; reserved bits come back as zero
        if (io_req.rd) begin
            if (io_req.addr == `GFX_INDEX_ADDR) begin
                rd = {4'h0, st.gidx};
            end else if (io_req.addr == `GFX_DATA_ADDR) begin
                case (st.gidx)
                    `IDX_FILL:     rd = {4'h0, st.fill};
                    `IDX_FILL_EN:  rd = {4'h0, st.fill_en};
                    `IDX_REF:      rd = {4'h0, st.ref_col};
                    `IDX_OPSHIFT:  rd = {3'h0, st.op_shift};
                    `IDX_RD_PLANE: rd = {6'h00, st.rd_plane};
                    `IDX_MODE:     rd = st.mode;
                    `IDX_MAP:      rd = {4'h0, st.map};
                    `IDX_IGNORE:   rd = {4'h0, st.ignore};
                    `IDX_BIT_MASK: rd = st.bit_mask;
                    default:       rd = `READ_ZERO;
                endcase
            end else if (crt_idx_hit) begin
                rd = st.cidx;
            end else if (crt_data_hit && st.cidx == `CRT_IDX_LATCH) begin
                rd = st.latch[st.rd_plane];
            end
            next_st.io_rdata  = rd;
            next_st.io_rvalid = 1'b1;
        end

        // Host memory write: form all four plane bytes
        if (mem_req.wr) begin
            next_st.plane_we = 1'b1;
            for (int p = 0; p < 4; p++) begin
                case (gfx_pkg::write_mode_t'(wmode))
                    gfx_pkg::WMODE_0: begin
                        src  = st.fill_en[p] ? spread(st.fill[p]) : rotated;
                        mask = st.bit_mask;
                    end
                    gfx_pkg::WMODE_1: begin
                        src  = st.latch[p];
                        mask = `ALL_ONES;
                    end
                    gfx_pkg::WMODE_2: begin
                        src  = spread(mem_req.data[p]);
                        mask = st.bit_mask;
                    end
                    gfx_pkg::WMODE_3: begin
                        src  = spread(st.fill[p]);
                        mask = rotated & st.bit_mask;
                    end
                    default: begin
                        src  = st.latch[p];
                        mask = `ALL_ONES;
                    end
                endcase
                if (wmode != gfx_pkg::WMODE_1) begin
                    src = apply_op(op, src, st.latch[p]);
                end
                next_st.plane_wdata[p] = (src & mask) | (st.latch[p] & ~mask);
            end
        end

        // Host memory read: load latches and form the read byte
        if (mem_req.rd) begin
            next_st.latch      = plane_rdata;
            next_st.mem_rvalid = 1'b1;
            if (st.mode[`MODE_COMPARE_READ_BIT]) begin
                for (int b = 0; b < 8; b++) begin
                    rd[b] = 1'b1;
                    for (int p = 0; p < 4; p++) begin
                        if (st.ignore[p] && (plane_rdata[p][b] != st.ref_col[p])) begin
                            rd[b] = 1'b0;
                        end
                    end
                end
                next_st.mem_rdata = rd;
            end else begin
                next_st.mem_rdata = plane_rdata[st.rd_plane];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign io_rdata    = st.io_rdata;
    assign io_rvalid   = st.io_rvalid;
    assign plane_wdata = st.plane_wdata;
    assign plane_we    = st.plane_we;
    assign mem_rdata   = st.mem_rdata;
    assign mem_rvalid  = st.mem_rvalid;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_index_upper_zero: assert property (
        io_req.rd && io_req.addr == `GFX_INDEX_ADDR |=> io_rdata[7:4] == 4'h0)
        else $error("index port upper bits not zero");

    a_data_port_echo: assert property (
        io_req.wr && io_req.addr == `GFX_DATA_ADDR && st.gidx == `IDX_BIT_MASK
        ##1 io_req.rd && io_req.addr == `GFX_DATA_ADDR && !io_req.wr
        |=> io_rdata == $past(io_req.data, 2))
        else $error("data port read does not return written value");

    a_reserved_zero: assert property (
        io_req.rd && io_req.addr == `GFX_DATA_ADDR && st.gidx <= `IDX_OPSHIFT
        |=> io_rdata[7:5] == 3'h0)
        else $error("reserved register bits not zero");

    a_fill_mode3: assert property (
        mem_req.wr && wmode == gfx_pkg::WMODE_3 && op == gfx_pkg::OP_PASS
        && st.bit_mask == `ALL_ONES && mem_req.data == `ALL_ONES
        |=> plane_we && plane_wdata[2] == spread($past(st.fill[2])))
        else $error("write mode 3 did not use fill colour");

    a_fill_enable_m0: assert property (
        mem_req.wr && wmode == gfx_pkg::WMODE_0 && op == gfx_pkg::OP_PASS
        && st.bit_mask == `ALL_ONES && !st.fill_en[1]
        |=> plane_wdata[1] == rotate_right($past(mem_req.data), $past(shift)))
        else $error("disabled plane did not take rotated host data");

    a_latch_copy_m1: assert property (
        mem_req.wr && wmode == gfx_pkg::WMODE_1 && !mem_req.rd
        |=> plane_wdata == $past(st.latch))
        else $error("write mode 1 did not copy latches");

    a_mask_keeps_latch: assert property (
        mem_req.wr |=> ((plane_wdata[0] ^ $past(st.latch[0])) & ~$past(st.bit_mask)) == 8'h00
        || $past(wmode) == gfx_pkg::WMODE_1)
        else $error("masked bit changed");

    a_latch_load: assert property (
        mem_req.rd |=> mem_rvalid && st.latch == $past(plane_rdata)
        ##1 mem_rvalid == $past(mem_req.rd))
        else $error("latches not loaded on read");

    a_compare_all_ignored: assert property (
        mem_req.rd && st.mode[`MODE_COMPARE_READ_BIT] && st.ignore == 4'h0
        |=> mem_rvalid && mem_rdata == `ALL_ONES)
        else $error("ignored planes took part in compare");

    a_compare_mismatch: assert property (
        mem_req.rd && st.mode[`MODE_COMPARE_READ_BIT] && st.ignore[0]
        && plane_rdata[0][0] != st.ref_col[0]
        |=> mem_rvalid && !mem_rdata[0])
        else $error("mismatching pixel did not read zero");

    a_single_plane_read: assert property (
        mem_req.rd && !st.mode[`MODE_COMPARE_READ_BIT]
        |=> mem_rvalid && mem_rdata == $past(plane_rdata[st.rd_plane]))
        else $error("plane read returned the wrong plane");

    a_rotate_zero: assert property (
        mem_req.wr && wmode == gfx_pkg::WMODE_0 && op == gfx_pkg::OP_PASS
        && shift == 3'h0 && st.bit_mask == `ALL_ONES && !st.fill_en[0]
        |=> plane_wdata[0] == $past(mem_req.data))
        else $error("zero shift count changed write data");

    a_xor_op_m2: assert property (
        mem_req.wr && wmode == gfx_pkg::WMODE_2 && op == gfx_pkg::OP_XOR
        |=> ((plane_wdata[1] ^ spread($past(mem_req.data[1])) ^ $past(st.latch[1]))
             & $past(st.bit_mask)) == `READ_ZERO)
        else $error("XOR logic op result wrong");

    a_io_answer_pulse: assert property (
        io_rvalid == $past(io_req.rd))
        else $error("I/O read answer not one cycle after the read");

    a_mem_answer_pulse: assert property (
        mem_rvalid == $past(mem_req.rd) && plane_we == $past(mem_req.wr))
        else $error("memory answer not one cycle after the request");

    a_latch_readback: assert property (
        io_req.rd && crt_data_hit && st.cidx == `CRT_IDX_LATCH && !mem_req.rd
        |=> io_rdata == $past(st.latch[st.rd_plane]))
        else $error("latch read-back wrong");

    c_write_mode3: cover property (mem_req.wr && wmode == gfx_pkg::WMODE_3);
    c_compare_read: cover property (mem_req.rd && st.mode[`MODE_COMPARE_READ_BIT]);
    c_xor_mode2: cover property (mem_req.wr && wmode == gfx_pkg::WMODE_2 && op == gfx_pkg::OP_XOR);
    c_read_then_write: cover property (mem_req.rd ##1 mem_req.wr);
    c_latch_readback: cover property (io_req.rd && crt_data_hit);

endmodule // planar_graphics_pixel_datapath

// File: tb/host_model.sv
// Host processor model issuing graphics I/O and memory cycles
`timescale 1ns/1ps
`include "gfx_cfg.svh"

module host_model (
    input  wire logic        ref_clk,
    output gfx_pkg::io_req_t  io_req,
    output gfx_pkg::mem_req_t mem_req,
    input  wire logic [7:0]  io_rdata,
    input  wire logic        io_rvalid,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        mem_rvalid
);
    // ************************************************************
    // Bus cycles
    // ************************************************************
    initial begin
        io_req  = '0;
        mem_req = '0;
    end

    // Each cycle sets both buses once, so no signal changes twice in one step
    task automatic cyc(input gfx_pkg::io_req_t i, input gfx_pkg::mem_req_t m);
        io_req  = i;
        mem_req = m;
        @(posedge ref_clk);
        #2;
    endtask

    task automatic idle();
        cyc('0, '0);
    endtask

    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        cyc('{wr: 1'b1, rd: 1'b0, addr: a, data: d}, '0);
    endtask

    // Returns {valid, data} one cycle after the read is taken
    task automatic io_rd(input logic [15:0] a, output logic [8:0] r);
        cyc('{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00}, '0);
        r = {io_rvalid, io_rdata};
    endtask

    task automatic reg_wr(input logic [3:0] idx, input logic [7:0] v);
        io_wr(`GFX_INDEX_ADDR, {4'h0, idx});
        io_wr(`GFX_DATA_ADDR, v);
    endtask

    task automatic reg_rd(input logic [3:0] idx, output logic [8:0] r);
        io_wr(`GFX_INDEX_ADDR, {4'h0, idx});
        io_rd(`GFX_DATA_ADDR, r);
    endtask

    task automatic mem_rd(output logic [8:0] r);
        cyc('0, '{wr: 1'b0, rd: 1'b1, data: 8'h00});
        r = {mem_rvalid, mem_rdata};
    endtask

    task automatic mem_wr(input logic [7:0] d);
        cyc('0, '{wr: 1'b1, rd: 1'b0, data: d});
    endtask
endmodule // host_model

// File: tb/planar_graphics_pixel_datapath_tb.sv
// Self-checking testbench of the graphics pixel datapath
`timescale 1ns/1ps
`include "gfx_cfg.svh"

module planar_graphics_pixel_datapath_tb;
    logic              ref_clk;
    logic              rst_b;
    gfx_pkg::io_req_t  io_req;
    gfx_pkg::mem_req_t mem_req;
    gfx_pkg::planes_t  plane_rdata;
    gfx_pkg::planes_t  plane_wdata;
    gfx_pkg::planes_t  mem_q;
    gfx_pkg::planes_t  latch;
    logic [7:0]        io_rdata;
    logic [7:0]        mem_rdata;
    logic              io_rvalid;
    logic              mem_rvalid;
    logic              plane_we;
    logic [8:0]        rv;
    logic [31:0]       seed;
    logic [3:0]        fill;
    logic [3:0]        fill_en;
    logic [3:0]        ref_c;
    logic [3:0]        ignore;
    logic [4:0]        op_shift;
    logic [1:0]        rd_plane;
    logic [1:0]        wm;
    logic              compare_read_select;
    logic [7:0]        wd;
    gfx_pkg::planes_t  ew;
    logic [7:0]        bit_mask;
    int                errors;
    int                checks;

    // ************************************************************
    // Clock, plane memory, instances
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    assign plane_rdata = mem_q;

    planar_graphics_pixel_datapath u_dut (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .io_req      (io_req),
        .io_rdata    (io_rdata),
        .io_rvalid   (io_rvalid),
        .mem_req     (mem_req),
        .plane_rdata (plane_rdata),
        .plane_wdata (plane_wdata),
        .plane_we    (plane_we),
        .mem_rdata   (mem_rdata),
        .mem_rvalid  (mem_rvalid)
    );

    host_model u_host (
        .ref_clk    (ref_clk),
        .io_req     (io_req),
        .mem_req    (mem_req),
        .io_rdata   (io_rdata),
        .io_rvalid  (io_rvalid),
        .mem_rdata  (mem_rdata),
        .mem_rvalid (mem_rvalid)
    );

    // ************************************************************
    // Reference functions and checks
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        logic [31:0] x;
        x = s;
        for (int k = 0; k < 32; k++) begin
            x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
        end
        return x;
    endfunction

    function automatic logic [7:0] rotr(input logic [7:0] d, input logic [2:0] n);
        return 8'({d, d} >> n);
    endfunction

    function automatic logic [7:0] alu(input logic [7:0] s, input logic [7:0] l);
        case (op_shift[4:3])
            2'h1: return s & l;
            2'h2: return s | l;
            2'h3: return s ^ l;
            default: return s;
        endcase
    endfunction

    function automatic gfx_pkg::planes_t exp_write(input logic [7:0] d);
        gfx_pkg::planes_t r;
        logic [7:0]       src;
        logic [7:0]       m;
        for (int p = 0; p < 4; p++) begin
            src = (wm == 2'h2) ? {8{d[p]}} :
                  (wm == 2'h3 || fill_en[p]) ? {8{fill[p]}} : rotr(d, op_shift[2:0]);
            m = (wm == 2'h3) ? (rotr(d, op_shift[2:0]) & bit_mask) : bit_mask;
            r[p] = (wm == 2'h1) ? latch[p] : ((alu(src, latch[p]) & m) | (latch[p] & ~m));
        end
        return r;
    endfunction

    function automatic logic [7:0] exp_read(input gfx_pkg::planes_t pl);
        logic [7:0] r;
        for (int b = 0; b < 8; b++) begin
            r[b] = 1'b1;
            for (int p = 0; p < 4; p++) begin
                if (ignore[p] && pl[p][b] != ref_c[p]) begin
                    r[b] = 1'b0;
                end
            end
        end
        return compare_read_select ? r : pl[rd_plane];
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        errors++;
        report_and_stop();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        errors = 0;
        checks = 0;
        seed   = 32'hE3EF218E;
        mem_q  = '0;
        latch  = '0;
        rst_b  = 1'b0;
        repeat (5) @(posedge ref_clk);
        #2;
        rst_b = 1'b1;
        for (int i = 0; i < 4; i++) begin
            u_host.reg_wr(4'(i), 8'hFF);
            u_host.reg_rd(4'(i), rv);
            check("reg_readback", {1'b1, (i == 3) ? 8'h1F : 8'h0F}, 32'(rv));
        end
        u_host.io_wr(`GFX_INDEX_ADDR, 8'hF7);
        u_host.io_rd(`GFX_INDEX_ADDR, rv);
        check("index_port", 32'h107, 32'(rv));
        for (int it = 0; it < 300; it++) begin
            seed     = lfsr(seed);
            fill     = seed[3:0];
            fill_en  = seed[7:4];
            ref_c    = seed[11:8];
            ignore   = seed[15:12];
            op_shift = seed[20:16];
            rd_plane = seed[22:21];
            wm       = seed[24:23];
            compare_read_select = seed[25];
            bit_mask = seed[31:26] == 6'h00 ? 8'hFF : {seed[31:26], seed[1:0]};
            if (it < 16) begin
                wm            = 2'(it);
                op_shift[4:3] = 2'(it >> 2);
            end
            // Corner cases: unrotated host data, then a solid fill in write mode 3
            if (it == 0) begin
                fill_en       = 4'h0;
                op_shift[2:0] = 3'h0;
            end
            if (it == 0 || it == 3) begin
                bit_mask = 8'hFF;
            end
            u_host.reg_wr(`IDX_FILL, {4'h0, fill});
            u_host.reg_wr(`IDX_FILL_EN, {4'h0, fill_en});
            u_host.reg_wr(`IDX_REF, {4'h0, ref_c});
            u_host.reg_wr(`IDX_OPSHIFT, {3'h0, op_shift});
            u_host.reg_wr(`IDX_RD_PLANE, {6'h00, rd_plane});
            u_host.reg_wr(`IDX_MODE, {4'h0, compare_read_select, 1'b0, wm});
            u_host.reg_wr(`IDX_IGNORE, {4'h0, ignore});
            u_host.reg_wr(`IDX_BIT_MASK, bit_mask);
            u_host.io_rd(`GFX_DATA_ADDR, rv);
            check("bit_mask", {1'b1, bit_mask}, 32'(rv));
            seed  = lfsr(seed);
            mem_q = seed;
            u_host.mem_rd(rv);
            check("mem_rdata", {1'b1, exp_read(mem_q)}, 32'(rv));
            latch = mem_q;
            seed  = lfsr(seed);
            wd    = (it == 3) ? 8'hFF : seed[7:0];
            u_host.mem_wr(wd);
            ew    = exp_write(wd);
            check("plane_we", 32'h1, 32'(plane_we));
            check("wd_lo", 32'(ew[1:0]), 32'(plane_wdata[1:0]));
            check("wd_hi", 32'(ew[3:2]), 32'(plane_wdata[3:2]));
            u_host.io_wr(`CRT_INDEX_COLOUR, `CRT_IDX_LATCH);
            u_host.io_rd(`CRT_DATA_COLOUR, rv);
            check("latch_readback", {1'b1, latch[rd_plane]}, 32'(rv));
        end
        u_host.idle();
        report_and_stop();
    end
endmodule // planar_graphics_pixel_datapath_tb
